//--- inc/qdm_pkg.sv
package qdm_pkg;

   localparam int QDM_NCH = 4;

   // serial (I2C / SPI) register addresses
   localparam logic [7:0] QDM_ADDR_NOP = 8'h00;
   localparam logic [7:0] QDM_ADDR_HI [QDM_NCH] = '{8'h01, 8'h07, 8'h0D, 8'h13};
   localparam logic [7:0] QDM_ADDR_LO [QDM_NCH] = '{8'h02, 8'h08, 8'h0E, 8'h14};
   localparam logic [7:0] QDM_ADDR_CFG [QDM_NCH] = '{8'h03, 8'h09, 8'h0F, 8'h15};

   // paged PMBus space
   localparam logic [7:0] QDM_PAGE_COMMON = 8'hFF;
   localparam logic [7:0] QDM_PAGE_LAST_CH = 8'h03;
   localparam logic [7:0] QDM_CMD_NOP = 8'hD0;
   localparam logic [7:0] QDM_CMD_HI = 8'h25;
   localparam logic [7:0] QDM_CMD_LO = 8'h26;
   localparam logic [7:0] QDM_CMD_CFG [QDM_NCH] = '{8'hD1, 8'hD5, 8'hD9, 8'hDD};

   // field layout
   localparam logic [15:0] QDM_NOP_VALUE = 16'h0000;
   localparam logic [15:0] QDM_MARGIN_MASK_12 = 16'hFFF0;
   localparam logic [15:0] QDM_MARGIN_MASK_10 = 16'hFFC0;
   localparam logic [15:0] QDM_CFG_MASK = 16'h1C1F;
   localparam int QDM_GAIN_MSB = 12;
   localparam int QDM_GAIN_LSB = 10;
   localparam logic [2:0] QDM_GAIN_EXT_REF = 3'h0;
   localparam logic [15:0] QDM_REG_RESET = 16'h0000;

   typedef struct packed {
      logic valid;
      logic write;
      logic pmbus;
      logic [7:0] page;
      logic [7:0] addr;
      logic [15:0] wdata;
   } qdm_req_t;

   typedef struct packed {
      logic [15:0] hi;
      logic [15:0] lo;
      logic [15:0] cfg;
   } qdm_chan_t;

   typedef struct packed {
      logic valid;
      logic err;
      logic [15:0] rdata;
   } qdm_rsp_t;

endpackage

//--- src/qdm_regbank.sv
// What this block does
// - address zero is a read-only word reading all zero, writes ignored
// - upper margin code sits in bits 15..4, read/write, resets to zero
// - lower margin code sits in bits 15..4, read/write, resets to zero
// - 10-bit variant keeps upper code in bits 15..6; bits 5..4 ignored
// - 10-bit variant keeps lower code in bits 15..6; bits 5..4 ignored
// - upper margin registers at serial addresses 01h, 07h, 0Dh, 13h
// - lower margin registers at serial addresses 02h, 08h, 0Eh, 14h
// - PMBus command 25h on page equal to channel reaches upper margin
// - PMBus command 26h on page equal to channel reaches lower margin
// - gain/comparator setup at serial 03h, 09h, 0Fh, 15h, reset zero
// - gain/comparator setup on page FFh, commands D1h, D5h, D9h, DDh
// - gain field bits 12..10 code 000 selects external reference unity gain
`timescale 1ns/10ps
`default_nettype none

module qdm_regbank
   import qdm_pkg::*;
#(
   parameter int RES_BITS = 12
)
(
   input wire logic core_clk,
   input wire logic rst,
   input wire qdm_req_t req,
   output qdm_rsp_t rsp_q,
   output qdm_chan_t [QDM_NCH-1:0] chan_q,
   output logic [QDM_NCH-1:0] ext_ref_q
);

   // 10-bit parts drop the two lowest code bits of the margin field
   localparam logic [15:0] MARGIN_MASK = (RES_BITS == 10) ? QDM_MARGIN_MASK_10
                                                          : QDM_MARGIN_MASK_12;

   logic sel_nop;
   logic [QDM_NCH-1:0] sel_hi;
   logic [QDM_NCH-1:0] sel_lo;
   logic [QDM_NCH-1:0] sel_cfg;
   logic hit;
   logic do_wr;
   qdm_rsp_t rsp_d;
   qdm_chan_t chan_d [QDM_NCH];
   logic ext_ref_d [QDM_NCH];

   // address decode, both address spaces share one register set
   always_comb
   begin
      sel_nop = 1'b0;
      sel_hi = '0;
      sel_lo = '0;
      sel_cfg = '0;
      if (req.pmbus)
      begin
         sel_nop = (req.page == QDM_PAGE_COMMON) && (req.addr == QDM_CMD_NOP);
         for (int i = 0; i < QDM_NCH; i++)
         begin
            sel_hi[i] = (req.page == 8'(i)) && (req.addr == QDM_CMD_HI);
            sel_lo[i] = (req.page == 8'(i)) && (req.addr == QDM_CMD_LO);
            sel_cfg[i] = (req.page == QDM_PAGE_COMMON) && (req.addr == QDM_CMD_CFG[i]);
         end
      end
      else
      begin
         sel_nop = (req.addr == QDM_ADDR_NOP);
         for (int i = 0; i < QDM_NCH; i++)
         begin
            sel_hi[i] = (req.addr == QDM_ADDR_HI[i]);
            sel_lo[i] = (req.addr == QDM_ADDR_LO[i]);
            sel_cfg[i] = (req.addr == QDM_ADDR_CFG[i]);
         end
      end
      hit = sel_nop | (|sel_hi) | (|sel_lo) | (|sel_cfg);
      do_wr = req.valid && req.write;
   end

   // read path; every taken request is answered one cycle later
   always_comb
   begin
      rsp_d = '0;
      if (req.valid)
      begin
         rsp_d.valid = 1'b1;
         rsp_d.err = !hit;
         if (!req.write)
         begin
            rsp_d.rdata = QDM_NOP_VALUE;
            for (int i = 0; i < QDM_NCH; i++)
            begin
               if (sel_hi[i])
                  rsp_d.rdata = chan_q[i].hi;
               if (sel_lo[i])
                  rsp_d.rdata = chan_q[i].lo;
               if (sel_cfg[i])
                  rsp_d.rdata = chan_q[i].cfg;
            end
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         rsp_q <= '0;
      else
         rsp_q <= rsp_d;
   end

   genvar g;
   generate
      for (g = 0; g < QDM_NCH; g++)
      begin : g_ch
         always_comb
         begin
            chan_d[g] = chan_q[g];
            if (do_wr && sel_hi[g])
               chan_d[g].hi = req.wdata & MARGIN_MASK;
            if (do_wr && sel_lo[g])
               chan_d[g].lo = req.wdata & MARGIN_MASK;
            if (do_wr && sel_cfg[g])
               chan_d[g].cfg = req.wdata & QDM_CFG_MASK;
            // external reference at gain code 000
            ext_ref_d[g] = (chan_d[g].cfg[QDM_GAIN_MSB:QDM_GAIN_LSB] == QDM_GAIN_EXT_REF);
         end

         always_ff @(posedge core_clk or posedge rst)
         begin
            if (rst)
            begin
               chan_q[g] <= {QDM_REG_RESET, QDM_REG_RESET, QDM_REG_RESET};
               ext_ref_q[g] <= 1'b1;
            end
            else
            begin
               chan_q[g] <= chan_d[g];
               ext_ref_q[g] <= ext_ref_d[g];
            end
         end

         property p_hi_ser_wr;
            @(posedge core_clk) disable iff (rst)
            (req.valid && req.write && !req.pmbus && req.addr == QDM_ADDR_HI[g])
            |=> (chan_q[g].hi == ($past(req.wdata) & MARGIN_MASK));
         endproperty
         a_hi_ser_wr: assert property (p_hi_ser_wr)
            else $error("upper margin serial write not stored");

         property p_lo_ser_wr;
            @(posedge core_clk) disable iff (rst)
            (req.valid && req.write && !req.pmbus && req.addr == QDM_ADDR_LO[g])
            |=> (chan_q[g].lo == ($past(req.wdata) & MARGIN_MASK));
         endproperty
         a_lo_ser_wr: assert property (p_lo_ser_wr)
            else $error("lower margin serial write not stored");

         property p_hi_pm_wr;
            @(posedge core_clk) disable iff (rst)
            (req.valid && req.write && req.pmbus && req.page == 8'(g) && req.addr == QDM_CMD_HI)
            |=> (chan_q[g].hi == ($past(req.wdata) & MARGIN_MASK));
         endproperty
         a_hi_pm_wr: assert property (p_hi_pm_wr)
            else $error("upper margin paged write not stored");

         property p_lo_pm_wr;
            @(posedge core_clk) disable iff (rst)
            (req.valid && req.write && req.pmbus && req.page == 8'(g) && req.addr == QDM_CMD_LO)
            |=> (chan_q[g].lo == ($past(req.wdata) & MARGIN_MASK));
         endproperty
         a_lo_pm_wr: assert property (p_lo_pm_wr)
            else $error("lower margin paged write not stored");

         property p_cfg_ser_wr;
            @(posedge core_clk) disable iff (rst)
            (req.valid && req.write && !req.pmbus && req.addr == QDM_ADDR_CFG[g])
            |=> (chan_q[g].cfg == ($past(req.wdata) & QDM_CFG_MASK));
         endproperty
         a_cfg_ser_wr: assert property (p_cfg_ser_wr)
            else $error("setup serial write not stored");

         property p_cfg_pm_wr;
            @(posedge core_clk) disable iff (rst)
            (req.valid && req.write && req.pmbus && req.page == QDM_PAGE_COMMON
             && req.addr == QDM_CMD_CFG[g])
            |=> (chan_q[g].cfg == ($past(req.wdata) & QDM_CFG_MASK));
         endproperty
         a_cfg_pm_wr: assert property (p_cfg_pm_wr)
            else $error("setup paged write not stored");

         property p_dontcare_zero;
            @(posedge core_clk) disable iff (rst)
            ((chan_q[g].hi & ~MARGIN_MASK) == 16'h0000)
            && ((chan_q[g].lo & ~MARGIN_MASK) == 16'h0000)
            && ((chan_q[g].cfg & ~QDM_CFG_MASK) == 16'h0000);
         endproperty
         a_dontcare_zero: assert property (p_dontcare_zero)
            else $error("don't-care bits hold nonzero value");

         property p_ext_ref;
            @(posedge core_clk) disable iff (rst)
            ext_ref_q[g] == (chan_q[g].cfg[QDM_GAIN_MSB:QDM_GAIN_LSB] == QDM_GAIN_EXT_REF);
         endproperty
         a_ext_ref: assert property (p_ext_ref)
            else $error("external reference flag disagrees with gain field");

         property p_hi_rd;
            @(posedge core_clk) disable iff (rst)
            (req.valid && !req.write && !req.pmbus && req.addr == QDM_ADDR_HI[g])
            |=> (rsp_q.valid && !rsp_q.err && rsp_q.rdata == $past(chan_q[g].hi));
         endproperty
         a_hi_rd: assert property (p_hi_rd)
            else $error("upper margin read returned wrong value");

         property p_lo_rd;
            @(posedge core_clk) disable iff (rst)
            (req.valid && !req.write && req.pmbus && req.page == 8'(g) && req.addr == QDM_CMD_LO)
            |=> (rsp_q.valid && rsp_q.rdata == $past(chan_q[g].lo));
         endproperty
         a_lo_rd: assert property (p_lo_rd)
            else $error("lower margin read returned wrong value");

         property p_lo_ser_rd;
            @(posedge core_clk) disable iff (rst)
            (req.valid && !req.write && !req.pmbus && req.addr == QDM_ADDR_LO[g])
            |=> (rsp_q.valid && !rsp_q.err && rsp_q.rdata == $past(chan_q[g].lo));
         endproperty
         a_lo_ser_rd: assert property (p_lo_ser_rd)
            else $error("lower margin serial read returned wrong value");

         property p_hi_pm_rd;
            @(posedge core_clk) disable iff (rst)
            (req.valid && !req.write && req.pmbus && req.page == 8'(g) && req.addr == QDM_CMD_HI)
            |=> (rsp_q.valid && !rsp_q.err && rsp_q.rdata == $past(chan_q[g].hi));
         endproperty
         a_hi_pm_rd: assert property (p_hi_pm_rd)
            else $error("upper margin paged read returned wrong value");

         property p_cfg_ser_rd;
            @(posedge core_clk) disable iff (rst)
            (req.valid && !req.write && !req.pmbus && req.addr == QDM_ADDR_CFG[g])
            |=> (rsp_q.valid && !rsp_q.err && rsp_q.rdata == $past(chan_q[g].cfg));
         endproperty
         a_cfg_ser_rd: assert property (p_cfg_ser_rd)
            else $error("setup serial read returned wrong value");

         property p_cfg_pm_rd;
            @(posedge core_clk) disable iff (rst)
            (req.valid && !req.write && req.pmbus && req.page == QDM_PAGE_COMMON
             && req.addr == QDM_CMD_CFG[g])
            |=> (rsp_q.valid && !rsp_q.err && rsp_q.rdata == $past(chan_q[g].cfg));
         endproperty
         a_cfg_pm_rd: assert property (p_cfg_pm_rd)
            else $error("setup paged read returned wrong value");
      end
   endgenerate

   property p_nop_rd;
      @(posedge core_clk) disable iff (rst)
      (req.valid && !req.write && !req.pmbus && req.addr == QDM_ADDR_NOP)
      |=> (rsp_q.valid && !rsp_q.err && rsp_q.rdata == 16'h0000);
   endproperty
   a_nop_rd: assert property (p_nop_rd)
      else $error("no-operation word did not read zero");

   property p_nop_pm_rd;
      @(posedge core_clk) disable iff (rst)
      (req.valid && !req.write && req.pmbus && req.page == QDM_PAGE_COMMON
       && req.addr == QDM_CMD_NOP)
      |=> (rsp_q.valid && !rsp_q.err && rsp_q.rdata == 16'h0000);
   endproperty
   a_nop_pm_rd: assert property (p_nop_pm_rd)
      else $error("paged no-operation word did not read zero");

   property p_nop_wr_inert;
      @(posedge core_clk) disable iff (rst)
      (req.valid && req.write && !req.pmbus && req.addr == QDM_ADDR_NOP)
      |=> (chan_q == $past(chan_q));
   endproperty
   a_nop_wr_inert: assert property (p_nop_wr_inert)
      else $error("write to no-operation word changed state");

   property p_unmapped;
      @(posedge core_clk) disable iff (rst)
      (req.valid && !hit) |=> (rsp_q.valid && rsp_q.err && rsp_q.rdata == 16'h0000);
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped access not flagged");

   c_pm_hi_rd: cover property (@(posedge core_clk) disable iff (rst)
      req.valid && !req.write && req.pmbus && req.page == QDM_PAGE_LAST_CH
      && req.addr == QDM_CMD_HI);
   c_cfg_wr_gain: cover property (@(posedge core_clk) disable iff (rst)
      $fell(ext_ref_q[0]));
   c_wr_then_rd: cover property (@(posedge core_clk) disable iff (rst)
      (req.valid && req.write && sel_lo[2]) ##1 (req.valid && !req.write && sel_lo[2]));
   c_unmapped: cover property (@(posedge core_clk) disable iff (rst)
      rsp_q.valid && rsp_q.err);

endmodule // qdm_regbank

`default_nettype wire

//--- sim/qdm_host.sv
`timescale 1ns/10ps
`default_nettype none

module qdm_host
   import qdm_pkg::*;
(
   input wire logic core_clk,
   output qdm_req_t req,
   input wire qdm_rsp_t rsp
);
   initial req = '0;

   // one request, then idle lines show the inverse so stale data never matches
   task automatic xfer(input logic wr, input logic pm, input logic [7:0] pg,
      input logic [7:0] ad, input logic [15:0] wd, output logic [15:0] rd,
      output logic er);
      @(posedge core_clk);
      req <= '{valid: 1'b1, write: wr, pmbus: pm, page: pg, addr: ad, wdata: wd};
      @(posedge core_clk);
      req <= '{valid: 1'b0, write: ~wr, pmbus: ~pm, page: ~pg, addr: ~ad, wdata: ~wd};
      #1;
      rd = rsp.rdata;
      er = rsp.valid ? rsp.err : 1'bx;
   endtask
endmodule // qdm_host

`default_nettype wire

//--- sim/quad_dac_margin_register_map_test.sv
`timescale 1ns/10ps
`default_nettype none

module quad_dac_margin_register_map_test
   import qdm_pkg::*;
;
   logic core_clk;
   logic rst;
   qdm_req_t req;
   qdm_rsp_t rsp_q;
   qdm_chan_t [QDM_NCH-1:0] chan_q;
   qdm_chan_t [QDM_NCH-1:0] chan_s;
   logic [QDM_NCH-1:0] ext_ref_q;
   logic [15:0] wv [QDM_NCH];
   int n_mismatch = 0;
   int cmp_count = 0;
   int cyc = 0;

   qdm_regbank #(.RES_BITS(12)) i_qdm_regbank (.core_clk(core_clk), .rst(rst),
      .req(req), .rsp_q(rsp_q), .chan_q(chan_q), .ext_ref_q(ext_ref_q));
   // short variant shares the request stream; only its stored codes are watched
   qdm_regbank #(.RES_BITS(10)) i_qdm_regbank_short (.core_clk(core_clk), .rst(rst),
      .req(req), .rsp_q(), .chan_q(chan_s), .ext_ref_q());
   qdm_host i_qdm_host (.core_clk(core_clk), .req(req), .rsp(rsp_q));

   initial
   begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   task automatic print_verdict;
      $display("compares=%0d mismatches=%0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic acc(input logic wr, input logic pm, input logic [7:0] pg,
      input logic [7:0] ad, input logic [15:0] wd, input logic [15:0] exp_rd,
      input logic exp_er);
      logic [15:0] rd;
      logic er;
      i_qdm_host.xfer(wr, pm, pg, ad, wd, rd, er);
      chk(rd, exp_rd);
      chk({15'h0000, er}, {15'h0000, exp_er});
   endtask

   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         n_mismatch++;
         print_verdict();
      end
   end

   initial
   begin
      rst = 1'b1;
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      acc(1'b0, 1'b0, 8'h00, QDM_ADDR_NOP, 16'h0000, 16'h0000, 1'b0);
      chk(16'(ext_ref_q), 16'h000F);
      for (int c = 0; c < QDM_NCH; c++)
      begin
         acc(1'b0, 1'b0, 8'h00, QDM_ADDR_HI[c], 16'h0000, 16'h0000, 1'b0);
         acc(1'b0, 1'b0, 8'h00, QDM_ADDR_LO[c], 16'h0000, 16'h0000, 1'b0);
         acc(1'b0, 1'b0, 8'h00, QDM_ADDR_CFG[c], 16'h0000, 16'h0000, 1'b0);
      end
      for (int c = 0; c < QDM_NCH; c++)
      begin
         wv[c] = 16'h9E7B ^ (16'h1248 << c);
         acc(1'b1, 1'b0, 8'h00, QDM_ADDR_HI[c], wv[c], 16'h0000, 1'b0);
         acc(1'b1, 1'b0, 8'h00, QDM_ADDR_LO[c], ~wv[c], 16'h0000, 1'b0);
         acc(1'b1, 1'b0, 8'h00, QDM_ADDR_CFG[c], 16'hFFFF, 16'h0000, 1'b0);
         chk(chan_q[c].hi, wv[c] & 16'hFFF0);
         chk(chan_q[c].lo, ~wv[c] & 16'hFFF0);
         chk(chan_s[c].hi, wv[c] & 16'hFFC0);
         chk(chan_s[c].lo, ~wv[c] & 16'hFFC0);
         chk({15'h0000, ext_ref_q[c]}, 16'h0000);
      end
      for (int c = 0; c < QDM_NCH; c++)
      begin
         acc(1'b0, 1'b1, 8'(c), QDM_CMD_HI, 16'h0000, wv[c] & 16'hFFF0, 1'b0);
         acc(1'b0, 1'b1, 8'(c), QDM_CMD_LO, 16'h0000, ~wv[c] & 16'hFFF0, 1'b0);
         acc(1'b0, 1'b1, 8'hFF, QDM_CMD_CFG[c], 16'h0000, 16'h1C1F, 1'b0);
      end
      // writes to the no-operation word must leave every register alone
      acc(1'b1, 1'b0, 8'h00, QDM_ADDR_NOP, 16'hFFFF, 16'h0000, 1'b0);
      acc(1'b0, 1'b0, 8'h00, QDM_ADDR_NOP, 16'h0000, 16'h0000, 1'b0);
      acc(1'b0, 1'b1, 8'hFF, QDM_CMD_NOP, 16'h0000, 16'h0000, 1'b0);
      chk(chan_q[0].hi, wv[0] & 16'hFFF0);
      acc(1'b0, 1'b0, 8'h00, 8'h04, 16'h0000, 16'h0000, 1'b1);
      acc(1'b0, 1'b1, 8'h04, QDM_CMD_HI, 16'h0000, 16'h0000, 1'b1);
      acc(1'b0, 1'b1, 8'h00, QDM_CMD_CFG[0], 16'h0000, 16'h0000, 1'b1);
      // paged writes; margin codes read back over the serial map, setup field checked on chan_q
      for (int c = 0; c < QDM_NCH; c++)
      begin
         acc(1'b1, 1'b1, 8'(c), QDM_CMD_HI, ~wv[c], 16'h0000, 1'b0);
         acc(1'b1, 1'b1, 8'(c), QDM_CMD_LO, wv[c], 16'h0000, 1'b0);
         acc(1'b1, 1'b1, 8'hFF, QDM_CMD_CFG[c], 16'h0400 << c, 16'h0000, 1'b0);
         chk({15'h0000, ext_ref_q[c]}, (c == 3) ? 16'h0001 : 16'h0000);
         chk(chan_q[c].cfg, (16'h0400 << c) & 16'h1C1F);
         acc(1'b0, 1'b0, 8'h00, QDM_ADDR_HI[c], 16'h0000, ~wv[c] & 16'hFFF0, 1'b0);
         acc(1'b0, 1'b0, 8'h00, QDM_ADDR_LO[c], 16'h0000, wv[c] & 16'hFFF0, 1'b0);
         chk(chan_s[c].hi, ~wv[c] & 16'hFFC0);
         chk(chan_s[c].lo, wv[c] & 16'hFFC0);
      end
      acc(1'b1, 1'b0, 8'h00, QDM_ADDR_CFG[2], 16'hE3FF, 16'h0000, 1'b0);
      chk({15'h0000, ext_ref_q[2]}, 16'h0001);
      acc(1'b0, 1'b0, 8'h00, QDM_ADDR_CFG[2], 16'h0000, 16'h001F, 1'b0);
      // second reset in mid-run clears the stored codes again
      @(posedge core_clk);
      rst <= 1'b1;
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      #1;
      chk(chan_q[1].hi, 16'h0000);
      acc(1'b0, 1'b0, 8'h00, QDM_ADDR_LO[3], 16'h0000, 16'h0000, 1'b0);
      print_verdict();
   end
endmodule // quad_dac_margin_register_map_test

`default_nettype wire
